// [hdl/lcalu_pkg.sv]
package lcalu_pkg;

  // ---------------------------------------------------------------
  // operation and operand form encodings
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    LCALU_OP_OR      = 2'b00,
    LCALU_OP_XOR     = 2'b01,
    LCALU_OP_COMPARE = 2'b10
  } lcalu_op_t;

  typedef enum logic [3:0] {
    LCALU_F_A_IMM    = 4'h0,
    LCALU_F_SADR_IMM = 4'h1,
    LCALU_F_A_R      = 4'h2,
    LCALU_F_R_A      = 4'h3,
    LCALU_F_A_SADR   = 4'h4,
    LCALU_F_A_ABS    = 4'h5,
    LCALU_F_A_PTR    = 4'h6,
    LCALU_F_A_PTR_D  = 4'h7,
    LCALU_F_A_PTR_B  = 4'h8,
    LCALU_F_A_PTR_C  = 4'h9
  } lcalu_form_t;

  typedef enum logic [1:0] {
    LCALU_S_IDLE = 2'b00,
    LCALU_S_RUN  = 2'b01,
    LCALU_S_DONE = 2'b10
  } lcalu_state_t;

  // ---------------------------------------------------------------
  // byte lengths
  // ---------------------------------------------------------------
  localparam logic [1:0] LCALU_LEN_1 = 2'h1;
  localparam logic [1:0] LCALU_LEN_2 = 2'h2;
  localparam logic [1:0] LCALU_LEN_3 = 2'h3;

  // ---------------------------------------------------------------
  // clock counts: fast (high-speed ram / no access) and slow
  // ---------------------------------------------------------------
  localparam logic [3:0] LCALU_CLK_REG       = 4'h4;
  localparam logic [3:0] LCALU_CLK_SADR_IMM_F = 4'h6;
  localparam logic [3:0] LCALU_CLK_SADR_IMM_S = 4'h8;
  localparam logic [3:0] LCALU_CLK_SADR_F    = 4'h4;
  localparam logic [3:0] LCALU_CLK_SADR_S    = 4'h5;
  localparam logic [3:0] LCALU_CLK_ABS_F     = 4'h8;
  localparam logic [3:0] LCALU_CLK_ABS_S     = 4'h9;
  localparam logic [3:0] LCALU_CLK_PTR_F     = 4'h4;
  localparam logic [3:0] LCALU_CLK_PTR_S     = 4'h5;
  localparam logic [3:0] LCALU_CLK_IDX_F     = 4'h8;
  localparam logic [3:0] LCALU_CLK_IDX_S     = 4'h9;

  // ---------------------------------------------------------------
  // flag byte bit positions and result reset value
  // ---------------------------------------------------------------
  localparam int         LCALU_ZERO_BIT  = 6;
  localparam int         LCALU_AUX_BIT   = 4;
  localparam int         LCALU_CARRY_BIT = 0;
  localparam logic [7:0] LCALU_RES_RST   = 8'h00;

endpackage

// [hdl/lcalu_core.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// combinational or / xor / compare core
// ---------------------------------------------------------------
module lcalu_core (
  input  wire logic [1:0] op,
  input  wire logic [7:0] dst,
  input  wire logic [7:0] src,
  output logic      [7:0] result,
  output logic            zero,
  output logic            aux_carry,
  output logic            carry,
  output logic            write_back
);

  logic [8:0] diff;
  logic [4:0] diff_lo;

  // compare subtracts with a ninth bit so the borrow is visible
  always_comb begin
    diff       = {1'b0, dst} - {1'b0, src};
    diff_lo    = {1'b0, dst[3:0]} - {1'b0, src[3:0]};
    aux_carry  = 1'b0;
    carry      = 1'b0;
    write_back = 1'b1;
    case (op)
      lcalu_pkg::LCALU_OP_OR: begin
        result = dst | src;
      end
      lcalu_pkg::LCALU_OP_XOR: begin
        result = dst ^ src;
      end
      lcalu_pkg::LCALU_OP_COMPARE: begin
        result     = diff[7:0];
        aux_carry  = diff_lo[4];
        carry      = diff[8];
        write_back = 1'b0;
      end
      default: begin
        result     = dst;
        write_back = 1'b0;
      end
    endcase
    zero = (result == 8'h00);
  end

endmodule

// [hdl/lcalu_exec.sv]
`timescale 1ns/1ps

module lcalu_exec (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [1:0] op,
  input  wire logic [3:0] form,
  input  wire logic       fast_ram,
  input  wire logic [7:0] dst_operand,
  input  wire logic [7:0] src_operand,
  input  wire logic       zero_in,
  input  wire logic       aux_carry_in,
  input  wire logic       carry_in,
  output logic            busy,
  output logic            done,
  output logic      [7:0] result,
  output logic            result_write,
  output logic            zero_flag,
  output logic            aux_carry_flag,
  output logic            carry_flag,
  output logic      [1:0] byte_length,
  output logic      [3:0] clock_count
);

  // ---------------------------------------------------------------
  // operating notes
  // ---------------------------------------------------------------
  // request side:
  //   start is looked at only while idle; a start seen while busy
  //   is dropped with no sign, so a caller waits for busy to fall
  //   op, form, operands and flags are latched on the taking edge,
  //   so they may change freely while busy is high
  // timing, counted from the taking edge as cycle zero:
  //   cycle 1: busy rises, byte_length and clock_count are valid
  //   cycle n: done stands for this one cycle, result_write too for or and xor,
  //     with n equal to clock_count
  //   cycle n+1: busy is low and the next start may be taken
  // clock counts:
  //   the short figure applies on fast ram hits and to forms that
  //   touch no data memory (register forms and the accumulator immediate form)
  //   the long figure applies to any other data area
  //   counts assume code runs from internal program memory; a
  //   slower fetch path needs its own wait logic upstream
  // flags:
  //   zero follows the eight-bit result for every op code
  //   compare also reports the half borrow and the full borrow
  //   or and xor pass aux carry and carry through untouched
  //   between start and done the flag outputs show the inputs
  //   captured at start, so a reader must wait for done
  // spare op code 3:
  //   nothing is written back, result echoes the destination,
  //   zero follows it and both carries are kept

  // ---------------------------------------------------------------
  // length and timing lookup
  // ---------------------------------------------------------------

  // bytes for a form, same for all three operations
  function automatic logic [1:0] form_len(input logic [3:0] f);
    case (f)
      lcalu_pkg::LCALU_F_SADR_IMM: form_len = lcalu_pkg::LCALU_LEN_3;
      lcalu_pkg::LCALU_F_A_ABS:    form_len = lcalu_pkg::LCALU_LEN_3;
      lcalu_pkg::LCALU_F_A_PTR:    form_len = lcalu_pkg::LCALU_LEN_1;
      default:                     form_len = lcalu_pkg::LCALU_LEN_2;
    endcase
  endfunction

  // clocks for a form; register forms have no data access so take
  // the fast figure regardless of the ram hint
  function automatic logic [3:0] form_clk(input logic [3:0] f,
                                          input logic       hit);
    case (f)
      lcalu_pkg::LCALU_F_SADR_IMM:
        form_clk = hit ? lcalu_pkg::LCALU_CLK_SADR_IMM_F
                       : lcalu_pkg::LCALU_CLK_SADR_IMM_S;
      lcalu_pkg::LCALU_F_A_SADR:
        form_clk = hit ? lcalu_pkg::LCALU_CLK_SADR_F
                       : lcalu_pkg::LCALU_CLK_SADR_S;
      lcalu_pkg::LCALU_F_A_ABS:
        form_clk = hit ? lcalu_pkg::LCALU_CLK_ABS_F
                       : lcalu_pkg::LCALU_CLK_ABS_S;
      lcalu_pkg::LCALU_F_A_PTR:
        form_clk = hit ? lcalu_pkg::LCALU_CLK_PTR_F
                       : lcalu_pkg::LCALU_CLK_PTR_S;
      lcalu_pkg::LCALU_F_A_PTR_D,
      lcalu_pkg::LCALU_F_A_PTR_B,
      lcalu_pkg::LCALU_F_A_PTR_C:
        form_clk = hit ? lcalu_pkg::LCALU_CLK_IDX_F
                       : lcalu_pkg::LCALU_CLK_IDX_S;
      lcalu_pkg::LCALU_F_A_IMM,
      lcalu_pkg::LCALU_F_A_R,
      lcalu_pkg::LCALU_F_R_A:
        form_clk = lcalu_pkg::LCALU_CLK_REG;
      default:  // spare codes run as register forms
        form_clk = lcalu_pkg::LCALU_CLK_REG;
    endcase
  endfunction

  // forms that read or write data memory; the others never wait on
  // a slow area, whatever the ram hint says
  function automatic logic form_has_access(input logic [3:0] f);
    case (f)
      lcalu_pkg::LCALU_F_SADR_IMM,
      lcalu_pkg::LCALU_F_A_SADR,
      lcalu_pkg::LCALU_F_A_ABS,
      lcalu_pkg::LCALU_F_A_PTR,
      lcalu_pkg::LCALU_F_A_PTR_D,
      lcalu_pkg::LCALU_F_A_PTR_B,
      lcalu_pkg::LCALU_F_A_PTR_C:
        form_has_access = 1'b1;
      default:
        form_has_access = 1'b0;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // count selection at the taking edge
  // ---------------------------------------------------------------
  logic       short_count;
  logic [3:0] take_clk;

  // one lookup feeds both the reported count and the down counter,
  // so the two can never disagree
  assign short_count = fast_ram || !form_has_access(form);
  assign take_clk    = form_clk(form, short_count);

  // ---------------------------------------------------------------
  // combinational core
  // ---------------------------------------------------------------
  logic [7:0] core_result;
  logic       core_zero;
  logic       core_aux;
  logic       core_carry;
  logic       core_wb;

  logic [1:0] op_q;
  logic [7:0] dst_q;
  logic [7:0] src_q;

  lcalu_core u_core (
    .op         (op_q),
    .dst        (dst_q),
    .src        (src_q),
    .result     (core_result),
    .zero       (core_zero),
    .aux_carry  (core_aux),
    .carry      (core_carry),
    .write_back (core_wb)
  );

  // ---------------------------------------------------------------
  // sequencer state
  // ---------------------------------------------------------------
  lcalu_pkg::lcalu_state_t state;
  lcalu_pkg::lcalu_state_t next_state;
  logic [3:0] remain;
  logic [3:0] next_remain;
  logic [1:0] next_op_q;
  logic [7:0] next_dst_q;
  logic [7:0] next_src_q;
  logic       aux_q;
  logic       carry_q;
  logic       next_aux_q;
  logic       next_carry_q;
  logic [1:0] next_byte_length;
  logic [3:0] next_clock_count;

  // one count per mclk edge: the instruction clock is the cpu clock,
  // so no prescaler sits in front of the counter
  always_comb begin
    next_state       = state;
    next_remain      = remain;
    next_op_q        = op_q;
    next_dst_q       = dst_q;
    next_src_q       = src_q;
    next_aux_q       = aux_q;
    next_carry_q     = carry_q;
    next_byte_length = byte_length;
    next_clock_count = clock_count;
    case (state)
      lcalu_pkg::LCALU_S_IDLE: begin
        if (start) begin
          next_op_q        = op;
          next_dst_q       = dst_operand;
          next_src_q       = src_operand;
          next_aux_q       = aux_carry_in;
          next_carry_q     = carry_in;
          next_byte_length = form_len(form);
          next_clock_count = take_clk;
          // start edge counts as the first clock
          next_remain      = take_clk - 4'h2;
          next_state       = lcalu_pkg::LCALU_S_RUN;
        end
      end
      lcalu_pkg::LCALU_S_RUN: begin
        if (remain == 4'h0) begin
          next_state = lcalu_pkg::LCALU_S_DONE;
        end else begin
          next_remain = remain - 4'h1;
        end
      end
      default: begin
        next_state = lcalu_pkg::LCALU_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state       <= lcalu_pkg::LCALU_S_IDLE;
      remain      <= 4'h0;
      op_q        <= lcalu_pkg::LCALU_OP_OR;
      dst_q       <= lcalu_pkg::LCALU_RES_RST;
      src_q       <= lcalu_pkg::LCALU_RES_RST;
      aux_q       <= 1'b0;
      carry_q     <= 1'b0;
      byte_length <= 2'h0;
      clock_count <= 4'h0;
    end else begin
      state       <= next_state;
      remain      <= next_remain;
      op_q        <= next_op_q;
      dst_q       <= next_dst_q;
      src_q       <= next_src_q;
      aux_q       <= next_aux_q;
      carry_q     <= next_carry_q;
      byte_length <= next_byte_length;
      clock_count <= next_clock_count;
    end
  end

  // ---------------------------------------------------------------
  // result and flag outputs
  // ---------------------------------------------------------------
  logic [7:0] next_result;
  logic       next_result_write;
  logic       next_zero_flag;
  logic       next_aux_flag;
  logic       next_carry_flag;
  logic       finishing;

  assign finishing = (state == lcalu_pkg::LCALU_S_RUN) && (remain == 4'h0);

  // outputs are loaded on the last clock so they line up with done
  always_comb begin
    next_result       = result;
    next_result_write = 1'b0;
    next_zero_flag    = zero_flag;
    next_aux_flag     = aux_carry_flag;
    next_carry_flag   = carry_flag;
    if (finishing) begin
      next_result       = core_result;
      next_result_write = core_wb;
      next_zero_flag    = core_zero;
      if (op_q == lcalu_pkg::LCALU_OP_COMPARE) begin
        next_aux_flag   = core_aux;
        next_carry_flag = core_carry;
      end else begin
        next_aux_flag   = aux_q;
        next_carry_flag = carry_q;
      end
    end else if (state == lcalu_pkg::LCALU_S_IDLE && start) begin
      // flags follow the caller until a new result replaces them
      next_zero_flag  = zero_in;
      next_aux_flag   = aux_carry_in;
      next_carry_flag = carry_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      result         <= lcalu_pkg::LCALU_RES_RST;
      result_write   <= 1'b0;
      zero_flag      <= 1'b0;
      aux_carry_flag <= 1'b0;
      carry_flag     <= 1'b0;
    end else begin
      result         <= next_result;
      result_write   <= next_result_write;
      zero_flag      <= next_zero_flag;
      aux_carry_flag <= next_aux_flag;
      carry_flag     <= next_carry_flag;
    end
  end

  // handshake outputs decoded from state
  assign busy = (state != lcalu_pkg::LCALU_S_IDLE);
  assign done = (state == lcalu_pkg::LCALU_S_DONE);

endmodule

// [sim/lcalu_exec_checker.sv]
`timescale 1ns/1ps
module lcalu_exec_checker (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       start,
  input wire logic [1:0] op,
  input wire logic [3:0] form,
  input wire logic       fast_ram,
  input wire logic [7:0] dst_operand,
  input wire logic [7:0] src_operand,
  input wire logic       aux_carry_in,
  input wire logic       carry_in,
  input wire logic       busy,
  input wire logic       done,
  input wire logic [7:0] result,
  input wire logic       result_write,
  input wire logic       zero_flag,
  input wire logic       aux_carry_flag,
  input wire logic       carry_flag,
  input wire logic [1:0] byte_length,
  input wire logic [3:0] clock_count
);
  // ---------------------------------------------------------------
  // capture at the taking edge, since inputs may move while busy
  // ---------------------------------------------------------------
  logic [1:0] op_q;
  logic [3:0] form_q;
  logic       fast_q;
  logic [7:0] dst_q;
  logic [7:0] src_q;
  logic       aux_q;
  logic       carry_q;
  logic [3:0] cnt;
  logic [7:0] exp_res;
  logic [1:0] exp_len;
  logic [3:0] exp_clk;

  always_ff @(posedge mclk) begin
    if (rst) begin
      {op_q, form_q, fast_q, dst_q, src_q, aux_q, carry_q} <= '0;
      cnt <= 4'h0;
    end else begin
      cnt <= busy ? cnt + 4'h1 : 4'h1;
      if (start && !busy) begin
        {op_q, form_q, fast_q} <= {op, form, fast_ram};
        {dst_q, src_q, aux_q, carry_q} <= {dst_operand, src_operand,
                                           aux_carry_in, carry_in};
      end
    end
  end

  // expected length, clock count and result of the captured request
  always_comb begin
    exp_len = 2'h2;
    exp_clk = 4'h4;
    exp_res = (op_q == 2'h0) ? (dst_q | src_q) :
              (op_q == 2'h1) ? (dst_q ^ src_q) :
              (op_q == 2'h2) ? (dst_q - src_q) : dst_q;
    case (form_q)
      4'h1: begin exp_len = 2'h3; exp_clk = fast_q ? 4'h6 : 4'h8; end
      4'h4: exp_clk = fast_q ? 4'h4 : 4'h5;
      4'h5: begin exp_len = 2'h3; exp_clk = fast_q ? 4'h8 : 4'h9; end
      4'h6: begin exp_len = 2'h1; exp_clk = fast_q ? 4'h4 : 4'h5; end
      4'h7, 4'h8, 4'h9: exp_clk = fast_q ? 4'h8 : 4'h9;
      default: ;
    endcase
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take; start && !busy; endsequence
  sequence s_hold; busy [*4]; endsequence

  a_busy_min_span: assert property (s_take |=> s_hold)
    else $error("busy shorter than four cycles");
  a_done_at_count: assert property (
    done |-> cnt == clock_count)
    else $error("done not at clock count");
  a_form_counts: assert property (
    $rose(busy) |-> clock_count == exp_clk && byte_length == exp_len)
    else $error("length or count wrong for form");
  a_done_single: assert property (done |=> !done && !busy)
    else $error("done longer than one cycle");
  a_or_value: assert property (done && op_q == 2'h0 |->
    result == (dst_q | src_q) && result_write)
    else $error("or result wrong");
  a_xor_value: assert property (done && op_q == 2'h1 |->
    result == (dst_q ^ src_q) && result_write)
    else $error("xor result wrong");
  a_compare_flags: assert property (
    done && op_q == 2'h2 |-> !result_write
    && carry_flag == (dst_q < src_q)
    && aux_carry_flag == (dst_q[3:0] < src_q[3:0]))
    else $error("compare flags wrong");
  a_zero_match: assert property (
    done |-> zero_flag == (exp_res == 8'h00))
    else $error("zero flag wrong");
  a_flags_kept: assert property (done && op_q inside {2'h0, 2'h1} |->
    aux_carry_flag == aux_q && carry_flag == carry_q)
    else $error("carry flags changed by logic op");
endmodule

bind lcalu_exec lcalu_exec_checker chk_u (
  .mclk(mclk), .rst(rst), .start(start), .op(op), .form(form),
  .fast_ram(fast_ram), .dst_operand(dst_operand),
  .src_operand(src_operand), .aux_carry_in(aux_carry_in),
  .carry_in(carry_in), .busy(busy), .done(done), .result(result),
  .result_write(result_write), .zero_flag(zero_flag),
  .aux_carry_flag(aux_carry_flag), .carry_flag(carry_flag),
  .byte_length(byte_length), .clock_count(clock_count));

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
  logic       mclk, rst, start, fast_ram, zero_in, aux_carry_in, carry_in;
  logic       busy, done, result_write, zero_flag, aux_carry_flag;
  logic       carry_flag;
  logic [1:0] op, byte_length;
  logic [3:0] form, clock_count;
  logic [7:0] dst_operand, src_operand, result;
  int         n_fail = 0;
  int         num_checks = 0;
  int         exp_q[$];

  lcalu_exec dut_u (.mclk(mclk), .rst(rst), .start(start), .op(op),
    .form(form), .fast_ram(fast_ram), .dst_operand(dst_operand),
    .src_operand(src_operand), .zero_in(zero_in),
    .aux_carry_in(aux_carry_in), .carry_in(carry_in), .busy(busy),
    .done(done), .result(result), .result_write(result_write),
    .zero_flag(zero_flag), .aux_carry_flag(aux_carry_flag),
    .carry_flag(carry_flag), .byte_length(byte_length),
    .clock_count(clock_count));

  // ---------------------------------------------------------------
  // clock, compare, closing
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task conclude;
    $display("checks=%0d failures=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog: the full run needs well under 2000 cycles
  initial begin
    #20000;
    n_fail++;
    conclude();
  end

  // one request, called at a rising edge; start is re-raised at random with junk
  // while busy so refusal is exercised on about half the transfers
  task run(input int o, input int f, input int fa, input int d,
           input int s);
    int r, len, clk, exp_aux, exp_carry, n, ai, ci, zi;
    ai = $urandom_range(1, 0);
    ci = $urandom_range(1, 0);
    zi = $urandom_range(1, 0);
    start <= 1'b1;
    {op, form, fast_ram} <= {o[1:0], f[3:0], fa[0]};
    {dst_operand, src_operand} <= {d[7:0], s[7:0]};
    {zero_in, aux_carry_in, carry_in} <= {zi[0], ai[0], ci[0]};
    // spare code 3 echoes the destination and writes nothing back
    r = (o == 0) ? (d | s) : (o == 1) ? (d ^ s) :
        (o == 2) ? ((d - s) & 255) : d;
    exp_q.push_back(r);
    exp_aux = (o == 2) ? int'((d % 16) < (s % 16)) : ai;
    exp_carry = (o == 2) ? int'(d < s) : ci;
    len = 2;
    clk = 4;
    case (f)
      1: begin len = 3; clk = fa ? 6 : 8; end
      4: clk = fa ? 4 : 5;
      5: begin len = 3; clk = fa ? 8 : 9; end
      6: begin len = 1; clk = fa ? 4 : 5; end
      7, 8, 9: clk = fa ? 8 : 9;
      default: ;
    endcase
    @(posedge mclk);
    start <= 1'($urandom_range(1, 0));
    op <= 2'($urandom_range(2, 0));
    dst_operand <= 8'($urandom());
    n = 1;
    while (n < 12) begin
      @(negedge mclk);
      if (done === 1'b1) break;
      // first busy cycle: flags still show what was handed in
      if (n == 1)
        chk({4'h0, busy, zero_flag, aux_carry_flag, carry_flag},
            {4'h0, 1'b1, zi[0], ai[0], ci[0]});
      @(posedge mclk);
      n++;
    end
    r = exp_q.pop_front();
    chk(n[7:0], clk[7:0]);
    chk({4'h0, clock_count}, clk[7:0]);
    chk({6'h0, byte_length}, len[7:0]);
    chk({7'h0, result_write}, {7'h0, o < 2});
    if (o != 2) chk(result, r[7:0]);
    chk({7'h0, zero_flag}, {7'h0, r == 0});
    chk({6'h0, aux_carry_flag, carry_flag},
        {6'h0, exp_aux[0], exp_carry[0]});
    @(posedge mclk);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int d, s;
    rst = 1'b1;
    {start, op, form, fast_ram, zero_in, aux_carry_in, carry_in} = '0;
    {dst_operand, src_operand} = '0;
    void'($urandom(32'h48B07625));
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    // every op code, the spare one too, every form, both areas
    for (int o = 0; o < 4; o++) begin
      for (int f = 0; f < 16; f++) begin
        for (int fa = 0; fa < 2; fa++) begin
          d = (f == 6) ? 0 : $urandom_range(255, 0);
          s = (f % 3 == 0) ? d : $urandom_range(255, 0);
          run(o, f, fa, d, s);
        end
      end
    end
    // reset in mid-transfer clears everything
    start <= 1'b1;
    form <= 4'h5;
    @(posedge mclk);
    @(posedge mclk);
    rst <= 1'b1;
    start <= 1'b0;
    @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    chk({3'h0, busy, done, result_write, zero_flag, carry_flag}, 8'h00);
    chk(result, 8'h00);
    chk({2'h0, byte_length, clock_count}, 8'h00);
    @(posedge mclk);
    run(1, 7, 0, 8'hA5, 8'hA5);
    conclude();
  end
endmodule
